// ### hw/csr_pkg.sv
/*
 * constants and types shared by the core state block: status bit positions,
 * register file geometry, pointer addresses, stack pointer reset and opcodes.
 * assumes a single core clock and no bus beyond the documented ports.
 */
package csr_pkg;
   // status register bit positions
   localparam int unsigned ST_IRQ = 7;
   localparam int unsigned ST_TBIT = 6;
   localparam int unsigned ST_HALF = 5;
   localparam int unsigned ST_SIGN = 4;
   localparam int unsigned ST_OVF = 3;
   localparam int unsigned ST_NEG = 2;
   localparam int unsigned ST_ZERO = 1;
   localparam int unsigned ST_CARRY = 0;
   localparam logic [7:0] STATUS_RESET = 8'h00;
   localparam logic [15:0] SP_RESET = 16'h0000;
   // working registers and the pointer pairs (low byte at even address)
   localparam int unsigned REG_COUNT = 32;
   localparam logic [4:0] REG_LAST_ADDR = 5'h1F;
   localparam logic [4:0] PTR_FIRST_ADDR = 5'h1A;
   localparam logic [4:0] PTR_SECOND_ADDR = 5'h1C;
   localparam logic [4:0] PTR_THIRD_ADDR = 5'h1E;
   localparam logic [15:0] DATA_SPACE_REG_TOP = 16'h001F;
   // stack step sizes
   localparam logic [15:0] SP_STEP_BYTE = 16'h0001;
   localparam logic [15:0] SP_STEP_ADDR = 16'h0002;

   // operation that moves the stack pointer
   typedef enum logic [2:0] {
      CSR_SP_NONE, CSR_SP_PUSH, CSR_SP_POP, CSR_SP_CALL, CSR_SP_RET
   } csr_sp_op_t;
   // pointer use in indirect addressing
   typedef enum logic [1:0] {
      CSR_PTR_DISP, CSR_PTR_POSTINC, CSR_PTR_PREDEC
   } csr_ptr_mode_t;
endpackage

// ### hw/csr_rf_if.sv
/*
 * carrier between the core top and its register file.
 * assumes one clock owned by the top; plain combinational request signals.
 */
`timescale 1ns/100ps
interface csr_rf_if;
   logic [4:0] rd_a_addr; // first operand index
   logic [4:0] rd_b_addr; // second operand index
   logic [7:0] rd_a; // first operand
   logic [7:0] rd_b; // second operand
   logic [15:0] rd_w; // pair read at rd_a_addr (even)
   logic wr_en; // byte write
   logic [4:0] wr_addr; // byte write index
   logic [7:0] wr_data; // byte write data
   logic wr_w_en; // pair write
   logic [4:0] wr_w_addr; // pair write index (even)
   logic [15:0] wr_w_data; // pair write data
   logic wr2_en; // second port byte write (pointer update)
   logic [4:0] wr2_addr; // second port index
   logic [7:0] wr2_data; // second port data
   modport core (output rd_a_addr, rd_b_addr, wr_en, wr_addr, wr_data, wr_w_en,
      wr_w_addr, wr_w_data, wr2_en, wr2_addr, wr2_data, input rd_a, rd_b, rd_w);
   modport file (input rd_a_addr, rd_b_addr, wr_en, wr_addr, wr_data, wr_w_en,
      wr_w_addr, wr_w_data, wr2_en, wr2_addr, wr2_data, output rd_a, rd_b, rd_w);
endinterface

// ### hw/csr_regfile.sv
/*
 * 32 x 8 working register file with two asynchronous byte reads, a pair read
 * and byte/pair writes. assumes the top gates writes with its clock enable.
 */
`timescale 1ns/100ps
module csr_regfile (
   input wire logic clk, // core clock
   input wire logic rst_n, // synchronous reset, active low
   csr_rf_if.file rf // access ports
);
   typedef struct packed {
      logic [csr_pkg::REG_COUNT-1:0][7:0] r;
   } csr_rf_state_t;
   csr_rf_state_t q, next_q;

   // reads are combinational so operand fetch, alu and write fit one cycle
   assign rf.rd_a = q.r[rf.rd_a_addr];
   assign rf.rd_b = q.r[rf.rd_b_addr];
   assign rf.rd_w = {q.r[{rf.rd_a_addr[4:1], 1'b1}], q.r[{rf.rd_a_addr[4:1], 1'b0}]};

   // later writes win: pair, then pointer update port, then byte
   always_comb begin
      next_q = q;
      if (rf.wr_w_en) begin
         next_q.r[{rf.wr_w_addr[4:1], 1'b0}] = rf.wr_w_data[7:0];
         next_q.r[{rf.wr_w_addr[4:1], 1'b1}] = rf.wr_w_data[15:8];
      end
      if (rf.wr2_en) begin
         next_q.r[rf.wr2_addr] = rf.wr2_data;
      end
      if (rf.wr_en) begin
         next_q.r[rf.wr_addr] = rf.wr_data;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end
endmodule

// ### hw/csr_sp.sv
/*
 * stack pointer: two byte registers, push/pop by one, call/return by two.
 * assumes at most one stack operation per cycle; enable gates all state.
 */
`timescale 1ns/100ps
module csr_sp (
   input wire logic clk, // core clock
   input wire logic rst_n, // synchronous reset, active low
   input wire logic ce, // clock enable
   input wire csr_pkg::csr_sp_op_t op, // stack movement
   input wire logic wr_lo, // software write of low byte
   input wire logic wr_hi, // software write of high byte
   input wire logic [7:0] wdata, // software data
   output logic [15:0] sp // current pointer
);
   typedef struct packed {
      logic [15:0] sp;
   } csr_sp_state_t;
   csr_sp_state_t q, next_q;
   assign sp = q.sp;

   // stack grows downward; software byte writes override the movement
   always_comb begin
      next_q = q;
      case (op)
         csr_pkg::CSR_SP_PUSH: next_q.sp = q.sp - csr_pkg::SP_STEP_BYTE;
         csr_pkg::CSR_SP_POP: next_q.sp = q.sp + csr_pkg::SP_STEP_BYTE;
         csr_pkg::CSR_SP_CALL: next_q.sp = q.sp - csr_pkg::SP_STEP_ADDR;
         csr_pkg::CSR_SP_RET: next_q.sp = q.sp + csr_pkg::SP_STEP_ADDR;
         default: next_q.sp = q.sp;
      endcase
      if (wr_lo) begin
         next_q.sp[7:0] = wdata;
      end
      if (wr_hi) begin
         next_q.sp[15:8] = wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         q.sp <= csr_pkg::SP_RESET;
      end else if (ce) begin
         q <= next_q;
      end
   end

   property p_sp_call;
      @(posedge clk) disable iff (!rst_n)
      (ce && op == csr_pkg::CSR_SP_CALL && !wr_lo && !wr_hi) |=> sp == $past(sp) - 16'h0002;
   endproperty
   a_sp_call: assert property (p_sp_call) else $error("call did not drop sp by two");
   property p_sp_pop;
      @(posedge clk) disable iff (!rst_n)
      (ce && op == csr_pkg::CSR_SP_POP && !wr_lo && !wr_hi) |=> sp == $past(sp) + 16'h0001;
   endproperty
   a_sp_pop: assert property (p_sp_pop) else $error("pop did not raise sp by one");
endmodule

// ### hw/csr_core.sv
/*
 * core state block: status flags, working registers with data-space view,
 * pointer pairs with indirect addressing modes, and the stack pointer.
 * assumes the decoder/alu drives one request set per core clock cycle.
 */
//Contract
// - status flags refresh after every alu operation from its result
// - bit 7 clear blocks every interrupt
// - taking an interrupt clears bit 7; interrupt return sets it
// - set/clear interrupt instructions drive bit 7
// - bit 6 stores a register bit; bit load writes it back
// - bit 5 is half carry from the low nibble
// - bit 4 always equals negative xor overflow; here it is refreshed only on alu updates, so a status write can break it
// - bit 3 is two's complement overflow
// - bit 2 flags a negative result
// - bit 1 flags a zero result
// - bit 0 flags a carry
// - file offers 8/8, 2x8/8, 2x8/16 and 16/16 access patterns
// - register n is data-space address n, 0 to 0x1F
// - registers 26..31 form three pointers, low byte even
// - pointers support displacement, post-increment and pre-decrement
// - stack grows down; byte push minus one, pop plus one
// - call and interrupt entry minus two; returns plus two
// - stack pointer is two read/write bytes resetting to zero
// - operands read, alu done and result written in one cycle
// - core runs on the clock directly, no division
// - fetch overlaps execute, up to one instruction per clock
`timescale 1ns/100ps
module csr_core (
   input wire logic CLK_SYS, // core clock, used undivided
   input wire logic RSTN, // synchronous reset, active low
   input wire logic CE, // clock enable, freezes all state when low
   input wire logic [4:0] RD_A_ADDR, // first operand index
   input wire logic [4:0] RD_B_ADDR, // second operand index
   output logic [7:0] RD_A, // first operand
   output logic [7:0] RD_B, // second operand
   output logic [15:0] RD_W, // pair at RD_A_ADDR, or at the selected pointer while PTR_EN
   input wire logic WR_EN, // byte result write
   input wire logic [4:0] WR_ADDR, // result index
   input wire logic [7:0] WR_DATA, // result byte
   input wire logic WR_W_EN, // pair result write
   input wire logic [4:0] WR_W_ADDR, // pair index
   input wire logic [15:0] WR_W_DATA, // pair result
   input wire logic ALU_UPD, // alu operation completes this cycle
   input wire logic [7:0] ALU_MASK, // status bits this operation affects
   input wire logic [7:0] ALU_RES, // result low byte
   input wire logic ALU_RES_W, // result is 16 bits wide
   input wire logic [15:0] ALU_RES16, // 16-bit result
   input wire logic ALU_C, // carry out
   input wire logic ALU_H, // carry out of low nibble
   input wire logic ALU_V, // two's complement overflow
   input wire logic STATUS_WR, // software write of status
   input wire logic [7:0] STATUS_WDATA, // status write data
   input wire logic IRQ_SET_OP, // set-interrupt instruction
   input wire logic IRQ_CLR_OP, // clear-interrupt instruction
   input wire logic IRQ_PENDING, // some enabled source requests service
   input wire logic IRQ_TAKE, // decoder enters an interrupt
   input wire logic IRQ_RETURN_OP, // return-from-interrupt executes
   input wire logic SUBROUTINE_RETURN_OP, // return from subroutine executes
   input wire logic CALL_OP, // subroutine call executes
   input wire logic PUSH_OP, // byte push
   input wire logic POP_OP, // byte pop
   input wire logic BIT_TO_STORE_OP, // copy a register bit into bit 6
   input wire logic BIT_FROM_STORE_OP, // copy bit 6 into a register bit
   input wire logic [4:0] BIT_REG, // register of the bit copy
   input wire logic [2:0] BIT_SEL, // bit position of the bit copy
   input wire logic SP_WR_LO, // software write, stack pointer low
   input wire logic SP_WR_HI, // software write, stack pointer high
   input wire logic [7:0] SP_WDATA, // stack pointer write data
   input wire logic PTR_EN, // indirect access this cycle
   input wire logic [1:0] PTR_SEL, // which pointer, 0..2
   input wire csr_pkg::csr_ptr_mode_t PTR_MODE, // displacement, post-inc, pre-dec
   input wire logic [5:0] PTR_DISP, // fixed displacement
   output logic [15:0] PTR_ADDR, // data-space address to access
   output logic PTR_IS_REG, // address falls in the register file
   output logic [4:0] PTR_REG_IDX, // register index when it does
   output logic IRQ_ACCEPT, // an interrupt may be taken now
   output logic [7:0] CORE_STATUS_FLAGS, // status register
   output logic [7:0] STACK_POINTER_LOW, // stack pointer low byte
   output logic [7:0] STACK_POINTER_HIGH // stack pointer high byte
);
   // ****************************************************************
   // helpers
   // ****************************************************************
   // maps a pointer number to the index of its low byte
   function automatic logic [4:0] ptr_base(input logic [1:0] sel);
      case (sel)
         2'd0: ptr_base = csr_pkg::PTR_FIRST_ADDR;
         2'd1: ptr_base = csr_pkg::PTR_SECOND_ADDR;
         default: ptr_base = csr_pkg::PTR_THIRD_ADDR;
      endcase
   endfunction

   // ****************************************************************
   // state
   // ****************************************************************
   typedef struct packed {
      logic [7:0] status;
   } csr_core_state_t;
   csr_core_state_t q, next_q;

   csr_rf_if rf ();
   csr_pkg::csr_sp_op_t sp_op;
   logic [15:0] sp;
   logic [15:0] ptr_val;
   logic [15:0] ptr_next;
   logic [4:0] ptr_idx;
   logic ptr_step;
   logic bit_wr;
   logic [7:0] bit_byte;
   logic [7:0] bit_reg_val;
   logic res_neg, res_zero;

   // ****************************************************************
   // register file and stack pointer
   // ****************************************************************
   csr_regfile u_rf (
      .clk(CLK_SYS),
      .rst_n(RSTN),
      .rf(rf)
   );

   // stack step: interrupt entry counts as a call, returns as a return
   always_comb begin
      sp_op = csr_pkg::CSR_SP_NONE;
      if (CALL_OP || IRQ_TAKE) begin
         sp_op = csr_pkg::CSR_SP_CALL;
      end else if (SUBROUTINE_RETURN_OP || IRQ_RETURN_OP) begin
         sp_op = csr_pkg::CSR_SP_RET;
      end else if (PUSH_OP) begin
         sp_op = csr_pkg::CSR_SP_PUSH;
      end else if (POP_OP) begin
         sp_op = csr_pkg::CSR_SP_POP;
      end
   end

   csr_sp u_sp (
      .clk(CLK_SYS),
      .rst_n(RSTN),
      .ce(CE),
      .op(sp_op),
      .wr_lo(SP_WR_LO),
      .wr_hi(SP_WR_HI),
      .wdata(SP_WDATA),
      .sp(sp)
   );
   assign STACK_POINTER_LOW = sp[7:0];
   assign STACK_POINTER_HIGH = sp[15:8];

   // ****************************************************************
   // register file ports, bit copy and pointer update
   // ****************************************************************
   // bit copy reads through port b; its write goes out on the byte port
   assign bit_reg_val = rf.rd_b;
   assign bit_wr = BIT_FROM_STORE_OP;
   always_comb begin
      bit_byte = bit_reg_val;
      bit_byte[BIT_SEL] = q.status[csr_pkg::ST_TBIT];
   end

   // pointer arithmetic; the update goes back through the second port and, for the high byte, the pair port
   assign ptr_idx = ptr_base(PTR_SEL);
   assign ptr_val = rf.rd_w;
   assign ptr_step = PTR_EN && PTR_MODE != csr_pkg::CSR_PTR_DISP;
   always_comb begin
      PTR_ADDR = ptr_val;
      ptr_next = ptr_val;
      case (PTR_MODE)
         csr_pkg::CSR_PTR_DISP: PTR_ADDR = ptr_val + {10'h000, PTR_DISP};
         csr_pkg::CSR_PTR_POSTINC: ptr_next = ptr_val + 16'h0001;
         csr_pkg::CSR_PTR_PREDEC: begin
            ptr_next = ptr_val - 16'h0001;
            PTR_ADDR = ptr_next;
         end
         default: PTR_ADDR = ptr_val;
      endcase
   end
   // registers appear at data-space addresses 0..0x1f
   assign PTR_IS_REG = PTR_ADDR <= csr_pkg::DATA_SPACE_REG_TOP;
   assign PTR_REG_IDX = PTR_ADDR[4:0];

   // one cycle: read, alu outside, write back at this edge
   always_comb begin
      rf.rd_a_addr = PTR_EN ? ptr_idx : RD_A_ADDR;
      rf.rd_b_addr = (BIT_TO_STORE_OP || bit_wr) ? BIT_REG : RD_B_ADDR;
      rf.wr_en = CE && (WR_EN || bit_wr);
      rf.wr_addr = bit_wr ? BIT_REG : WR_ADDR;
      rf.wr_data = bit_wr ? bit_byte : WR_DATA;
      rf.wr_w_en = CE && (WR_W_EN || ptr_step);
      rf.wr_w_addr = WR_W_EN ? WR_W_ADDR : ptr_idx;
      rf.wr_w_data = WR_W_EN ? WR_W_DATA : ptr_next;
      rf.wr2_en = CE && ptr_step;
      rf.wr2_addr = ptr_idx;
      rf.wr2_data = ptr_next[7:0];
   end
   // pointer high byte rides the pair port only when no pair result is pending
   // limitation: a pair result and a pointer step in one cycle, pair wins high byte
   assign RD_A = rf.rd_a;
   assign RD_B = rf.rd_b;
   assign RD_W = rf.rd_w;

   // ****************************************************************
   // status register
   // ****************************************************************
   assign res_neg = ALU_RES_W ? ALU_RES16[15] : ALU_RES[7];
   assign res_zero = ALU_RES_W ? (ALU_RES16 == 16'h0000) : (ALU_RES == 8'h00);

   // software write first, then flag refresh, then interrupt gate events
   always_comb begin
      next_q = q;
      if (STATUS_WR) begin
         next_q.status = STATUS_WDATA;
      end
      if (ALU_UPD) begin
         if (ALU_MASK[csr_pkg::ST_CARRY]) next_q.status[csr_pkg::ST_CARRY] = ALU_C;
         if (ALU_MASK[csr_pkg::ST_ZERO]) next_q.status[csr_pkg::ST_ZERO] = res_zero;
         if (ALU_MASK[csr_pkg::ST_NEG]) next_q.status[csr_pkg::ST_NEG] = res_neg;
         if (ALU_MASK[csr_pkg::ST_OVF]) next_q.status[csr_pkg::ST_OVF] = ALU_V;
         if (ALU_MASK[csr_pkg::ST_HALF]) next_q.status[csr_pkg::ST_HALF] = ALU_H;
      end
      // in every alu update cycle, sign follows negative and overflow whatever touched them
      if (ALU_UPD) begin
         next_q.status[csr_pkg::ST_SIGN] = next_q.status[csr_pkg::ST_NEG]
            ^ next_q.status[csr_pkg::ST_OVF];
      end
      if (BIT_TO_STORE_OP) begin
         next_q.status[csr_pkg::ST_TBIT] = bit_reg_val[BIT_SEL];
      end
      // entry clears the gate; it wins over any set in the same cycle
      if (IRQ_SET_OP || IRQ_RETURN_OP) begin
         next_q.status[csr_pkg::ST_IRQ] = 1'b1;
      end
      if (IRQ_CLR_OP || IRQ_TAKE) begin
         next_q.status[csr_pkg::ST_IRQ] = 1'b0;
      end
   end

   // no push of status on entry: software keeps it
   // one request set taken at each undivided clock edge where CE is high
   always_ff @(posedge CLK_SYS) begin
      if (!RSTN) begin
         q.status <= csr_pkg::STATUS_RESET;
      end else if (CE) begin
         q <= next_q;
      end
   end

   // clear-interrupt blocks an interrupt arriving in the same cycle
   assign IRQ_ACCEPT = IRQ_PENDING && q.status[csr_pkg::ST_IRQ] && !IRQ_CLR_OP;
   assign CORE_STATUS_FLAGS = q.status;

   // ****************************************************************
   // checks
   // ****************************************************************
   property p_gate_blocks;
      @(posedge CLK_SYS) disable iff (!RSTN)
      !CORE_STATUS_FLAGS[7] |-> !IRQ_ACCEPT;
   endproperty
   a_gate_blocks: assert property (p_gate_blocks) else $error("interrupt accepted while gated");
   property p_take_clears;
      @(posedge CLK_SYS) disable iff (!RSTN)
      (CE && IRQ_TAKE) |=> !CORE_STATUS_FLAGS[7];
   endproperty
   a_take_clears: assert property (p_take_clears) else $error("gate not cleared on entry");
   property p_irq_return_op_sets;
      @(posedge CLK_SYS) disable iff (!RSTN)
      (CE && IRQ_RETURN_OP && !IRQ_TAKE && !IRQ_CLR_OP) |=> CORE_STATUS_FLAGS[7];
   endproperty
   a_irq_return_op_sets: assert property (p_irq_return_op_sets) else $error("gate not set on return");
   property p_sign;
      @(posedge CLK_SYS) disable iff (!RSTN)
      $past(CE && ALU_UPD) |-> CORE_STATUS_FLAGS[4] == (CORE_STATUS_FLAGS[2] ^ CORE_STATUS_FLAGS[3]);
   endproperty
   a_sign: assert property (p_sign) else $error("sign is not n xor v");
   property p_zero;
      @(posedge CLK_SYS) disable iff (!RSTN)
      (CE && ALU_UPD && ALU_MASK[1] && !ALU_RES_W && !BIT_TO_STORE_OP)
         |=> CORE_STATUS_FLAGS[1] == ($past(ALU_RES) == 8'h00);
   endproperty
   a_zero: assert property (p_zero) else $error("zero flag wrong");
   property p_carry;
      @(posedge CLK_SYS) disable iff (!RSTN)
      (CE && ALU_UPD && ALU_MASK[0]) |=> CORE_STATUS_FLAGS[0] == $past(ALU_C);
   endproperty
   a_carry: assert property (p_carry) else $error("carry flag wrong");
   property p_tbit;
      @(posedge CLK_SYS) disable iff (!RSTN)
      (CE && BIT_TO_STORE_OP) |=> CORE_STATUS_FLAGS[6] == $past(bit_reg_val[BIT_SEL]);
   endproperty
   a_tbit: assert property (p_tbit) else $error("stored bit wrong");
   property p_reset;
      @(posedge CLK_SYS) !RSTN |=> CORE_STATUS_FLAGS == 8'h00 && sp == 16'h0000;
   endproperty
   a_reset: assert property (p_reset) else $error("reset values wrong");
   // a pointer step must carry or borrow into the high byte
   property p_ptr_step;
      @(posedge CLK_SYS) disable iff (!RSTN)
      (CE && PTR_EN && !WR_W_EN && !WR_EN && !bit_wr
         && (PTR_MODE == csr_pkg::CSR_PTR_POSTINC || PTR_MODE == csr_pkg::CSR_PTR_PREDEC))
         |=> {u_rf.q.r[{$past(ptr_idx[4:1]), 1'b1}], u_rf.q.r[$past(ptr_idx)]}
            == ($past(PTR_MODE == csr_pkg::CSR_PTR_POSTINC) ? $past(ptr_val) + 16'h0001
            : $past(ptr_val) - 16'h0001);
   endproperty
   a_ptr_step: assert property (p_ptr_step) else $error("pointer step lost a byte");
endmodule

// ### tb/csr_alu_model.sv
/*
 * behavioural adder standing in for the alu beside the core state block.
 * assumes its operands come straight from the file's combinational reads.
 */
`timescale 1ns/100ps
module csr_alu_model (
   input wire logic [7:0] a, // first operand
   input wire logic [7:0] b, // second operand
   output logic [7:0] res, // sum
   output logic c, // carry out
   output logic h, // carry out of the low nibble
   output logic v // two's complement overflow
);
   // ****************
   // adder
   // ****************
   logic [4:0] nib;
   // only addition is modelled: it alone drives every arithmetic flag
   always_comb begin
      {c, res} = {1'b0, a} + {1'b0, b};
      nib = {1'b0, a[3:0]} + {1'b0, b[3:0]};
      h = nib[4];
      v = (a[7] == b[7]) && (res[7] != a[7]);
   end
endmodule

// ### tb/csr_core_tb.sv
/*
 * self-checking bench for csr_core: stack pointer, register file, pointers,
 * flags and interrupt gate. assumes csr_alu_model adds the two operands.
 */
`timescale 1ns/100ps
module csr_core_tb;
   // ****************
   // signals and tables
   // ****************
   logic clk_sys, rstn, ce, wr_en, wr_w_en, alu_upd, st_wr, irq_set, irq_clr, irq_pend;
   logic irq_take, irq_ret, sub_ret, call_op, push_op, pop_op, b_to, b_from, sp_wr_lo;
   logic sp_wr_hi, ptr_en, use_alu, alu_c, alu_h, alu_v, ptr_is_reg, irq_acc;
   logic [4:0] ra, rb, wa, wwa, bit_reg, ptr_idx;
   logic [7:0] wd, alu_mask, st_wd, sp_wd, rd_a, rd_b, alu_res, status, stack_pointer_low, stack_pointer_high;
   logic [15:0] wwd, rd_w, ptr_addr, p;
   logic [2:0] bit_sel;
   logic [1:0] ptr_sel;
   logic [5:0] disp;
   csr_pkg::csr_ptr_mode_t ptr_mode;
   int n_errors, comparisons;
   // push, pop, return, call from 0x0200: the first borrows across the byte
   logic [15:0] sp_exp [4] = '{16'h01FF, 16'h0200, 16'h0202, 16'h0200};
   // nibble carry, signed overflow, wrap to zero, carry with overflow
   logic [7:0] op_a [4] = '{8'h0F, 8'h7F, 8'hFF, 8'h80};
   logic [7:0] op_b [4] = '{8'h01, 8'h01, 8'h01, 8'h80};
   logic [7:0] flg [4] = '{8'h20, 8'h2C, 8'h23, 8'h1B};

   csr_alu_model alu (.a(rd_a), .b(rd_b), .res(alu_res), .c(alu_c), .h(alu_h), .v(alu_v));
   csr_core uut (.CLK_SYS(clk_sys), .RSTN(rstn), .CE(ce), .RD_A_ADDR(ra), .RD_B_ADDR(rb),
      .RD_A(rd_a), .RD_B(rd_b), .RD_W(rd_w), .WR_EN(wr_en), .WR_ADDR(wa),
      .WR_DATA(use_alu ? alu_res : wd), .WR_W_EN(wr_w_en), .WR_W_ADDR(wwa), .WR_W_DATA(wwd),
      .ALU_UPD(alu_upd), .ALU_MASK(alu_mask), .ALU_RES(alu_res), .ALU_RES_W(1'b0),
      .ALU_RES16(16'h0000), .ALU_C(alu_c), .ALU_H(alu_h), .ALU_V(alu_v), .STATUS_WR(st_wr),
      .STATUS_WDATA(st_wd), .IRQ_SET_OP(irq_set), .IRQ_CLR_OP(irq_clr),
      .IRQ_PENDING(irq_pend), .IRQ_TAKE(irq_take), .IRQ_RETURN_OP(irq_ret),
      .SUBROUTINE_RETURN_OP(sub_ret), .CALL_OP(call_op), .PUSH_OP(push_op), .POP_OP(pop_op),
      .BIT_TO_STORE_OP(b_to), .BIT_FROM_STORE_OP(b_from), .BIT_REG(bit_reg),
      .BIT_SEL(bit_sel), .SP_WR_LO(sp_wr_lo), .SP_WR_HI(sp_wr_hi), .SP_WDATA(sp_wd),
      .PTR_EN(ptr_en), .PTR_SEL(ptr_sel), .PTR_MODE(ptr_mode), .PTR_DISP(disp),
      .PTR_ADDR(ptr_addr), .PTR_IS_REG(ptr_is_reg), .PTR_REG_IDX(ptr_idx),
      .IRQ_ACCEPT(irq_acc), .CORE_STATUS_FLAGS(status), .STACK_POINTER_LOW(stack_pointer_low),
      .STACK_POINTER_HIGH(stack_pointer_high));

   // ****************
   // access tasks
   // ****************
   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("FAIL %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic clr();
      {wr_en, wr_w_en, alu_upd, st_wr, irq_set, irq_clr, irq_take, irq_ret, sub_ret} = '0;
      {call_op, push_op, pop_op, b_to, b_from, sp_wr_lo, sp_wr_hi, ptr_en, use_alu} = '0;
   endtask
   // requests are taken at the rising edge and pulses drop at the next fall;
   // a quiet cycle follows so no strobe is lowered and raised in one step
   task automatic tick();
      @(negedge clk_sys);
      clr();
      @(negedge clk_sys);
   endtask
   task automatic wr8(input logic [4:0] a, input logic [7:0] d);
      {wr_en, wa, wd} = {1'b1, a, d};
      tick();
   endtask
   task automatic wr16(input logic [4:0] a, input logic [15:0] d);
      {wr_w_en, wwa, wwd} = {1'b1, a, d};
      tick();
   endtask
   // reads are combinational: a short settle is all they need
   task automatic rd(input logic [4:0] a, input logic [4:0] b);
      {ra, rb} = {a, b};
      #1;
   endtask
   task automatic spw(input logic [7:0] hi, input logic [7:0] lo);
      {sp_wr_hi, sp_wd} = {1'b1, hi};
      tick();
      {sp_wr_lo, sp_wd} = {1'b1, lo};
      tick();
   endtask
   // one-cycle add: operands out of regs 1 and 2, sum back into reg 5
   task automatic alu_op(input logic [7:0] a, input logic [7:0] b, input logic [7:0] m);
      wr8(5'h01, a);
      wr8(5'h02, b);
      {ra, rb, wa, alu_mask} = {5'h01, 5'h02, 5'h05, m};
      {use_alu, wr_en, alu_upd} = 3'h7;
      tick();
      rd(5'h05, 5'h05);
   endtask
   task automatic summarize();
      if (n_errors == 0 && comparisons > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // ****************
   // sequence
   // ****************
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   // the sequence needs about a hundred cycles; far more means a hang
   initial begin
      repeat (20000) @(posedge clk_sys);
      n_errors++;
      summarize();
   end
   initial begin
      clr();
      {rstn, irq_pend, ra, rb, wa, wwa, bit_reg, bit_sel, ptr_sel, disp} = '0;
      {wd, alu_mask, st_wd, sp_wd, wwd} = '0;
      ce = 1'b1;
      ptr_mode = csr_pkg::CSR_PTR_DISP;
      repeat (12) @(negedge clk_sys);
      rstn = 1'b1;
      chk("status reset", 16'h0000, {8'h00, status});
      chk("sp reset", 16'h0000, {stack_pointer_high, stack_pointer_low});
      spw(8'hA5, 8'h5A);
      chk("sp write", 16'hA55A, {stack_pointer_high, stack_pointer_low});
      spw(8'h02, 8'h00);
      for (int k = 0; k < 4; k++) begin
         {call_op, sub_ret, pop_op, push_op} = 4'h1 << k;
         tick();
         chk("sp step", sp_exp[k], {stack_pointer_high, stack_pointer_low});
      end
      ce = 1'b0;
      push_op = 1'b1;
      tick();
      ce = 1'b1;
      chk("sp frozen", 16'h0200, {stack_pointer_high, stack_pointer_low});
      wr8(5'h03, 8'h55);
      wr16(5'h1A, 16'h1234);
      rd(5'h1B, 5'h03);
      chk("pair high", 16'h0012, {8'h00, rd_a});
      chk("byte", 16'h0055, {8'h00, rd_b});
      rd(5'h1A, 5'h1B);
      chk("pair", 16'h1234, rd_w);
      // each pointer in turn; the middle one points past the file and
      // steps across its low byte, so the high byte must follow
      for (int i = 0; i < 3; i++) begin
         p = (i == 1) ? 16'h01FF : 16'h0010 + 16'(i);
         wr16(5'h1A + 5'(2 * i), p);
         {ptr_en, ptr_sel, disp} = {1'b1, 2'(i), 6'h03};
         ptr_mode = csr_pkg::CSR_PTR_DISP;
         #1;
         chk("disp address", p + 16'h0003, ptr_addr);
         chk("in file", {15'h0000, i != 1}, {15'h0000, ptr_is_reg});
         if (i != 1) chk("file index", {11'h000, p[4:0] + 5'h03}, {11'h000, ptr_idx});
         ptr_mode = csr_pkg::CSR_PTR_POSTINC;
         #1;
         chk("post-inc address", p, ptr_addr);
         tick();
         ptr_en = 1'b1;
         ptr_mode = csr_pkg::CSR_PTR_PREDEC;
         #1;
         chk("pre-dec address", p, ptr_addr);
         tick();
         rd(5'h1A + 5'(2 * i), 5'h00);
         chk("pointer back", p, rd_w);
      end
      {st_wr, st_wd} = {1'b1, 8'hC0};
      tick();
      for (int k = 0; k < 4; k++) begin
         alu_op(op_a[k], op_b[k], 8'h3F);
         chk("alu result", {8'h00, op_a[k] + op_b[k]}, {8'h00, rd_a});
         chk("flags", {8'h00, 8'hC0 | flg[k]}, {8'h00, status});
      end
      alu_op(8'h0F, 8'h01, 8'h01);
      chk("carry only", 16'h00DA, {8'h00, status});
      {b_to, bit_reg, bit_sel} = {1'b1, 5'h03, 3'h1};
      tick();
      chk("bit store", 16'h009A, {8'h00, status});
      {b_from, bit_reg, bit_sel} = {1'b1, 5'h03, 3'h2};
      tick();
      rd(5'h03, 5'h00);
      chk("bit load", 16'h0051, {8'h00, rd_a});
      {b_to, bit_reg, bit_sel} = {1'b1, 5'h03, 3'h0};
      tick();
      chk("bit store", 16'h00DA, {8'h00, status});
      irq_pend = 1'b1;
      #1;
      chk("accept", 16'h0001, {15'h0000, irq_acc});
      irq_clr = 1'b1;
      #1;
      chk("accept on clear", 16'h0000, {15'h0000, irq_acc});
      tick();
      chk("gate cleared", 16'h005A, {8'h00, status});
      chk("accept closed", 16'h0000, {15'h0000, irq_acc});
      irq_set = 1'b1;
      tick();
      chk("gate set", 16'h00DA, {8'h00, status});
      irq_take = 1'b1;
      tick();
      chk("entry gate", 16'h005A, {8'h00, status});
      chk("entry sp", 16'h01FE, {stack_pointer_high, stack_pointer_low});
      irq_ret = 1'b1;
      tick();
      chk("return gate", 16'h00DA, {8'h00, status});
      chk("return sp", 16'h0200, {stack_pointer_high, stack_pointer_low});
      irq_pend = 1'b0;
      summarize();
   end
endmodule
